/* logic/output_compare_unit.sv */
`timescale 1ns/1ps
`include "output_compare_map.svh"

module output_compare_unit (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic [3:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [15:0] rdata_out,
    input wire logic [15:0] timer_two_count_in,
    input wire logic [15:0] timer_three_count_in,
    input wire logic timer_period_in,
    input wire logic cpu_idle_in,
    input wire logic fault_input_a_in,
    input wire logic port_latch_in,
    output logic compare_output_pin_out,
    output logic compare_output_pin_oe_out,
    output logic irq_out
);

    ////////////////////////////////////////////////////////////////////////
    // State and decode

    output_compare_pkg::state_t st_reg; // Registered state
    output_compare_pkg::state_t st_next; // Next state
    logic [15:0] count; // Selected timer count
    logic match_pri; // Primary compare hit
    logic match_sec; // Secondary compare hit

    // Mode field of a control word
    function automatic logic [2:0] mode_of(input logic [15:0] c);
        mode_of = c[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
    endfunction

    // Pin level on entry to a mode, given current level and primary value
    function automatic logic entry_level(input logic [2:0] m, input logic cur,
                                         input logic [15:0] pri);
        unique case (m)
            `MODE_ONE_LOW: entry_level = 1'b1;
            `MODE_TOGGLE: entry_level = cur;
            `MODE_PWM, `MODE_PWM_FLT: entry_level = (pri != `VALUE_RESET);
            default: entry_level = 1'b0;
        endcase
    endfunction

    // Timer select bit picks the time base
    always_comb begin
        if (st_reg.ctrl[`CTRL_TSEL_BIT]) begin
            count = timer_three_count_in;
        end else begin
            count = timer_two_count_in;
        end
    end

    // Primary value comparator
    compare_match u_match_pri (
        .count_in(count),
        .prev_count_in(st_reg.prev_count),
        .value_in(st_reg.primary),
        .match_out(match_pri)
    );

    // Secondary value comparator
    compare_match u_match_sec (
        .count_in(count),
        .prev_count_in(st_reg.prev_count),
        .value_in(st_reg.secondary),
        .match_out(match_sec)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic [2:0] mode; // Active mode
        logic [2:0] new_mode; // Mode written this cycle
        logic run; // Channel not halted
        logic fault_now; // Synchronised fault asserted
        logic fault_fall; // Fault input falling edge
        logic new_pin; // Pin level after this cycle
        logic rise; // Output rising edge
        logic fall; // Output falling edge
        logic edge_ev; // Interrupt worthy output edge
        logic [1:0] ev; // Events this cycle
        logic ctrl_wr; // Control word written this cycle
        mode = 3'h0;
        new_mode = 3'h0;
        run = 1'b0;
        fault_now = 1'b0;
        fault_fall = 1'b0;
        new_pin = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        edge_ev = 1'b0;
        ev = 2'h0;
        ctrl_wr = 1'b0;
        st_next = st_reg;
        mode = mode_of(st_reg.ctrl);
        // Idle stop freezes the channel while the processor idles
        run = !(st_reg.ctrl[`CTRL_IDLE_BIT] && cpu_idle_in);
        // Control writes set the entry level instead of raising events
        ctrl_wr = wr_in && (addr_in == `ADDR_CTRL);

        // Fault input two-stage synchroniser
        st_next.fault_sync1 = fault_input_a_in;
        st_next.fault_sync2 = st_reg.fault_sync1;
        st_next.fault_prev = st_reg.fault_sync2;
        fault_now = !st_reg.fault_sync2;
        fault_fall = st_reg.fault_prev && !st_reg.fault_sync2;

        // Remember count so matches fire only on arrival
        if (run) begin
            st_next.prev_count = count;
        end

        new_pin = st_reg.pin;
        // Mode behaviour; a halted channel holds pin and sequence
        if (run) begin
            unique case (mode)
                // One-shot: armed by the control write, one transition at the match
                `MODE_ONE_HIGH, `MODE_ONE_LOW: begin
                    if (st_reg.seq == output_compare_pkg::ST_ARMED && match_pri) begin
                        new_pin = (mode == `MODE_ONE_HIGH);
                        st_next.seq = output_compare_pkg::ST_DONE;
                    end
                end
                // Toggle: every primary match flips the pin
                `MODE_TOGGLE: begin
                    if (match_pri) begin
                        new_pin = !st_reg.pin;
                    end
                end
                // Pulse modes: rise at primary, fall at secondary
                `MODE_DELAYED, `MODE_CONT: begin
                    if (st_reg.seq == output_compare_pkg::ST_ARMED) begin
                        if (match_pri) begin
                            new_pin = 1'b1;
                        end
                        if (match_sec && (st_reg.pin || match_pri)) begin
                            new_pin = 1'b0;
                            if (mode == `MODE_DELAYED) begin
                                st_next.seq = output_compare_pkg::ST_DONE;
                            end
                        end
                    end
                end
                // PWM: period start raises the pin, primary match lowers it
                `MODE_PWM, `MODE_PWM_FLT: begin
                    // Duty latched from secondary at each period
                    if (timer_period_in) begin
                        st_next.pwm_latch = st_reg.secondary;
                        // Zero duty keeps the pin low for the whole period
                        new_pin = (st_reg.secondary != `VALUE_RESET);
                    end else if (match_pri) begin
                        new_pin = 1'b0;
                    end
                    // Fault overrides the duty while it is asserted
                    if (mode == `MODE_PWM_FLT && fault_now) begin
                        new_pin = 1'b0;
                        st_next.flt = 1'b1;
                    end
                end
                // Disabled: the port latch owns the pin
                default: begin
                    new_pin = st_reg.pin;
                end
            endcase
        end

        // Fault flag is cleared by hardware once the fault goes away
        if (mode != `MODE_PWM_FLT || !fault_now) begin
            st_next.flt = (mode == `MODE_PWM_FLT) && fault_now;
        end

        // Register writes; reconfiguration assumes the timer is stopped
        if (wr_in) begin
            unique case (addr_in)
                `ADDR_CTRL: begin
                    // Unimplemented control bits are dropped and read as zero
                    st_next.ctrl = wdata_in & `CTRL_WRITE_MASK;
                    st_next.ctrl[`CTRL_FAULT_BIT] = 1'b0;
                    new_mode = mode_of(wdata_in);
                    new_pin = entry_level(new_mode, st_reg.pin, st_reg.primary);
                    st_next.seq = (new_mode == `MODE_OFF) ? output_compare_pkg::ST_IDLE
                                                         : output_compare_pkg::ST_ARMED;
                end
                // Compare values take effect on the next count step
                `ADDR_PRIMARY: st_next.primary = wdata_in;
                `ADDR_SECONDARY: st_next.secondary = wdata_in;
                // Status bits clear where a one is written
                `ADDR_STATUS: st_next.status = st_reg.status & ~wdata_in[1:0];
                // Mask gates status onto the interrupt line
                `ADDR_MASK: st_next.mask = wdata_in[1:0];
                default: begin
                    // Unmapped offsets ignore writes
                end
            endcase
        end

        // Output edges and their interrupt events
        rise = new_pin && !st_reg.pin;
        fall = !new_pin && st_reg.pin;
        // Each mode except off and the two PWM modes interrupts on its own output edge
        unique case (mode)
            `MODE_ONE_HIGH: edge_ev = rise;
            `MODE_ONE_LOW, `MODE_DELAYED, `MODE_CONT: edge_ev = fall;
            `MODE_TOGGLE: edge_ev = rise || fall;
            default: edge_ev = 1'b0;
        endcase
        // Entry level set by a control write is not an event; other writes
        // must not swallow a compare edge that lands in the same cycle
        ev[`EV_EDGE] = edge_ev && !ctrl_wr;
        ev[`EV_FAULT] = (mode == `MODE_PWM_FLT) && fault_fall;
        // Set wins over a clear in the same cycle
        st_next.status = st_next.status | ev;

        // Pin drive: disabled mode hands pin to the port latch
        st_next.pin = new_pin;
        st_next.pin_oe = (mode_of(st_next.ctrl) != `MODE_OFF);
        // Level interrupt while any unmasked event is pending
        st_next.irq = |(st_next.status & st_next.mask);

        // Read data in the cycle after the strobe
        st_next.rdata = 16'h0000;
        if (rd_in) begin
            unique case (addr_in)
                `ADDR_CTRL: begin
                    st_next.rdata = st_reg.ctrl;
                    st_next.rdata[`CTRL_FAULT_BIT] = st_reg.flt;
                end
                `ADDR_PRIMARY: st_next.rdata = st_reg.primary;
                `ADDR_SECONDARY: st_next.rdata = st_reg.secondary;
                // Event registers pad to the word width
                `ADDR_STATUS: st_next.rdata = {14'h0000, st_reg.status};
                `ADDR_MASK: st_next.rdata = {14'h0000, st_reg.mask};
                default: st_next.rdata = 16'h0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    // State register with asynchronous reset
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_reg.ctrl <= `CTRL_RESET;
            st_reg.primary <= `VALUE_RESET;
            st_reg.secondary <= `VALUE_RESET;
            st_reg.status <= `IRQ_RESET;
            st_reg.mask <= `IRQ_RESET;
            st_reg.pin <= 1'b0;
            st_reg.pin_oe <= 1'b0;
            st_reg.irq <= 1'b0;
            st_reg.rdata <= 16'h0000;
            st_reg.prev_count <= `VALUE_RESET;
            st_reg.pwm_latch <= `VALUE_RESET;
            // Fault pin idles high, so no false fall follows reset
            st_reg.fault_sync1 <= 1'b1;
            st_reg.fault_sync2 <= 1'b1;
            st_reg.fault_prev <= 1'b1;
            st_reg.flt <= 1'b0;
            st_reg.seq <= output_compare_pkg::ST_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // Pin mux: in disabled mode the port latch level passes through
    logic pin_q; // Registered pin level
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= (mode_of(st_next.ctrl) == `MODE_OFF) ? port_latch_in : st_next.pin;
        end
    end

    // Outputs come straight from their flip-flops
    assign compare_output_pin_out = pin_q;
    assign compare_output_pin_oe_out = st_reg.pin_oe;
    assign irq_out = st_reg.irq;
    assign rdata_out = st_reg.rdata;

endmodule

/* logic/output_compare_map.svh */
`ifndef OUTPUT_COMPARE_MAP_SVH
`define OUTPUT_COMPARE_MAP_SVH

// Register word offsets on the plain register port
`define ADDR_CTRL 4'h0
`define ADDR_PRIMARY 4'h1
`define ADDR_SECONDARY 4'h2
`define ADDR_STATUS 4'h3
`define ADDR_MASK 4'h4

// Control register field positions
`define CTRL_MODE_LSB 0
`define CTRL_MODE_MSB 2
`define CTRL_TSEL_BIT 3
`define CTRL_FAULT_BIT 4
`define CTRL_IDLE_BIT 13
// Writable control bits; the rest read as zero, except bit 4, which reads the fault flag
`define CTRL_WRITE_MASK 16'h200f

// Reset values
`define CTRL_RESET 16'h0000
`define VALUE_RESET 16'h0000
`define IRQ_RESET 2'h0

// Event bit positions in status and mask
`define EV_EDGE 0
`define EV_FAULT 1

// Mode codes
`define MODE_OFF 3'h0
`define MODE_ONE_HIGH 3'h1
`define MODE_ONE_LOW 3'h2
`define MODE_TOGGLE 3'h3
`define MODE_DELAYED 3'h4
`define MODE_CONT 3'h5
`define MODE_PWM 3'h6
`define MODE_PWM_FLT 3'h7

`endif

/* logic/output_compare_pkg.sv */
package output_compare_pkg;

    // Pin sequencing state
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ARMED = 3'b010,
        ST_DONE = 3'b100
    } seq_state_t;

    // Registered state of the channel
    typedef struct packed {
        logic [15:0] ctrl;
        logic [15:0] primary;
        logic [15:0] secondary;
        logic [1:0] status;
        logic [1:0] mask;
        logic pin;
        logic pin_oe;
        logic irq;
        logic [15:0] rdata;
        logic [15:0] prev_count;
        logic [15:0] pwm_latch;
        logic fault_sync1;
        logic fault_sync2;
        logic fault_prev;
        logic flt;
        seq_state_t seq;
    } state_t;

endpackage

/* logic/compare_match.sv */
`timescale 1ns/1ps

// Detects a fresh arrival of the timer at a compare value
module compare_match (
    input wire logic [15:0] count_in,
    input wire logic [15:0] prev_count_in,
    input wire logic [15:0] value_in,
    output logic match_out
);

    // Match only on the count step that lands on the value
    always_comb begin
        match_out = (count_in == value_in) && (prev_count_in != count_in);
    end

endmodule

/* test/output_compare_assertions.sv */
`timescale 1ns/1ps
`include "output_compare_map.svh"
// Port checks; shadows of control, primary and mask follow the writes
module output_compare_assertions (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic [3:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [15:0] rdata_out,
    input wire logic fault_input_a_in,
    input wire logic compare_output_pin_out,
    input wire logic compare_output_pin_oe_out,
    input wire logic irq_out
);
    logic [2:0] mode_reg; // Mode as last written
    logic [15:0] pri_reg; // Primary value as last written
    logic [1:0] mask_reg; // Mask as last written
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);
    // Shadow registers
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mode_reg <= 3'h0;
            pri_reg <= 16'h0000;
            mask_reg <= 2'h0;
        end else if (wr_in) begin
            if (addr_in == `ADDR_CTRL) mode_reg <= wdata_in[2:0];
            if (addr_in == `ADDR_PRIMARY) pri_reg <= wdata_in;
            if (addr_in == `ADDR_MASK) mask_reg <= wdata_in[1:0];
        end
    end
    property p_mode_oe;
        wr_in && addr_in == `ADDR_CTRL |=> ##1 compare_output_pin_oe_out == (mode_reg != 3'h0);
    endproperty
    a_mode_oe: assert property (p_mode_oe)
        else $error("pin enable does not follow mode");
    property p_low_start;
        wr_in && addr_in == `ADDR_CTRL && wdata_in[2:0] inside {3'h1, 3'h4, 3'h5}
            |=> ##1 !compare_output_pin_out;
    endproperty
    a_low_start: assert property (p_low_start)
        else $error("pin not low at entry");
    property p_high_start;
        wr_in && addr_in == `ADDR_CTRL && wdata_in[2:0] == 3'h2 |=> ##1 compare_output_pin_out;
    endproperty
    a_high_start: assert property (p_high_start)
        else $error("pin not high at entry");
    property p_pwm_start;
        wr_in && addr_in == `ADDR_CTRL && wdata_in[2:1] == 2'h3
            |=> ##1 compare_output_pin_out == ($past(pri_reg, 2) != 16'h0000);
    endproperty
    a_pwm_start: assert property (p_pwm_start)
        else $error("pwm entry level wrong");
    property p_keep;
        wr_in && addr_in == `ADDR_CTRL && wdata_in[2:0] == 3'h3
            |=> ##1 compare_output_pin_out == $past(compare_output_pin_out, 2);
    endproperty
    a_keep: assert property (p_keep)
        else $error("toggle entry changed pin");
    property p_mode_rd;
        rd_in && addr_in == `ADDR_CTRL |=> rdata_out[2:0] == $past(mode_reg);
    endproperty
    a_mode_rd: assert property (p_mode_rd)
        else $error("mode readback wrong");
    property p_no_irq;
        (mask_reg == 2'h0) [*3] |-> !irq_out;
    endproperty
    a_no_irq: assert property (p_no_irq)
        else $error("interrupt while all masked");
    property p_fault_low;
        (mode_reg == 3'h7 && !fault_input_a_in) [*5] |-> !compare_output_pin_out;
    endproperty
    a_fault_low: assert property (p_fault_low)
        else $error("pin not low under fault");
endmodule
bind output_compare_unit output_compare_assertions chk (.ref_clk_in, .nrst_in, .addr_in,
    .wdata_in, .wr_in, .rd_in, .rdata_out, .fault_input_a_in, .compare_output_pin_out,
    .compare_output_pin_oe_out, .irq_out);

/* test/timer_pair_model.sv */
`timescale 1ns/1ps
// Timers two and three; a stopped timer is cleared, as software does while it is off
module timer_pair_model (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [1:0] run_in,
    output logic [15:0] two_out,
    output logic [15:0] three_out,
    output logic period_out
);
    // Count up to a period of 40 and pulse at each wrap
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            two_out <= 16'h0000;
            three_out <= 16'h0000;
            period_out <= 1'b0;
        end else begin
            two_out <= (!run_in[0] || two_out == 16'h0027) ? 16'h0000 : two_out + 16'h0001;
            three_out <= (!run_in[1] || three_out == 16'h0027) ? 16'h0000 : three_out + 16'h0001;
            period_out <= (run_in[0] && two_out == 16'h0027)
                || (run_in[1] && three_out == 16'h0027);
        end
    end
endmodule

/* test/tb_top.sv */
`timescale 1ns/1ps
`include "output_compare_map.svh"
module tb_top;
    logic ref_clk_in;
    logic nrst_in;
    logic [3:0] addr_in;
    logic [15:0] wdata_in;
    logic wr_in;
    logic rd_in;
    logic [15:0] rdata_out;
    logic [15:0] timer_two_count_in;
    logic [15:0] timer_three_count_in;
    logic timer_period_in;
    logic cpu_idle_in;
    logic fault_input_a_in;
    logic port_latch_in;
    logic compare_output_pin_out;
    logic compare_output_pin_oe_out;
    logic irq_out;
    logic [1:0] run; // Timer run enables
    logic p; // Pin level after toggle entry
    int n_errors;
    int samples_checked;
    output_compare_unit DUT (.ref_clk_in, .nrst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
        .rdata_out, .timer_two_count_in, .timer_three_count_in, .timer_period_in,
        .cpu_idle_in, .fault_input_a_in, .port_latch_in, .compare_output_pin_out,
        .compare_output_pin_oe_out, .irq_out);
    timer_pair_model timers (.clk_in(ref_clk_in), .nrst_in, .run_in(run),
        .two_out(timer_two_count_in), .three_out(timer_three_count_in),
        .period_out(timer_period_in));
    initial begin
        ref_clk_in = 1'b0;
        forever #50 ref_clk_in = ~ref_clk_in;
    end
    task automatic end_of_test();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        samples_checked++;
        if (s !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask
    task automatic go(input logic [1:0] r);
        @(posedge ref_clk_in);
        run <= r;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge ref_clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rc(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
        @(posedge ref_clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge ref_clk_in);
        rd_in <= 1'b0;
        #1;
        chk("rdata", rdata_out & m, e);
    endtask
    // Stop the timers, write control, then clear stale events
    task automatic arm(input logic [15:0] c);
        go(2'b00);
        wr(`ADDR_CTRL, c);
        wr(`ADDR_STATUS, 16'h0003);
        tick(2);
    endtask
    task automatic wait_pin(input logic v);
        int i;
        i = 0;
        while (compare_output_pin_out !== v && i < 500) begin
            tick(1);
            i++;
        end
        if (i == 500) begin
            n_errors++;
            end_of_test();
        end
    endtask
    initial begin
        {addr_in, wdata_in, wr_in, rd_in, run, cpu_idle_in, port_latch_in} <= '0;
        fault_input_a_in <= 1'b1;
        nrst_in <= 1'b0;
        repeat (20) @(posedge ref_clk_in);
        nrst_in <= 1'b1;
        for (int a = 0; a < 5; a++) rc(a[3:0], 16'hffff, 16'h0000);
        wr(4'hf, 16'hffff);
        rc(4'hf, 16'hffff, 16'h0000);
        wr(`ADDR_PRIMARY, 16'h0005);
        wr(`ADDR_SECONDARY, 16'h0009);
        wr(`ADDR_MASK, 16'h0003);
        rc(`ADDR_SECONDARY, 16'hffff, 16'h0009);
        $display("registers done");
        for (int t = 0; t < 2; t++) begin
            arm({12'h000, t[0], 3'h1});
            go(t[0] ? 2'b01 : 2'b10);
            tick(60);
            chk("pin", compare_output_pin_out, 16'h0000);
            go(t[0] ? 2'b10 : 2'b01);
            wait_pin(1'b1);
            rc(`ADDR_STATUS, 16'h0003, 16'h0001);
            chk("irq", irq_out, 16'h0001);
            wr(`ADDR_STATUS, 16'h0001);
            tick(3);
            chk("irq", irq_out, 16'h0000);
        end
        arm(16'h0002);
        go(2'b01);
        wait_pin(1'b0);
        rc(`ADDR_STATUS, 16'h0003, 16'h0001);
        $display("one shot done");
        for (int m = 4; m < 6; m++) begin
            arm(m[15:0]);
            go(2'b01);
            wait_pin(1'b1);
            rc(`ADDR_STATUS, 16'h0003, 16'h0000);
            wait_pin(1'b0);
            rc(`ADDR_STATUS, 16'h0003, 16'h0001);
            tick(36);
            chk("pulse", compare_output_pin_out, m == 5 ? 16'h0001 : 16'h0000);
        end
        arm(16'h0003);
        p = compare_output_pin_out;
        go(2'b01);
        wait_pin(!p);
        wait_pin(p);
        rc(`ADDR_STATUS, 16'h0003, 16'h0001);
        $display("pulse and toggle done");
        arm(16'h0006);
        go(2'b01);
        wait_pin(1'b0);
        wait_pin(1'b1);
        rc(`ADDR_STATUS, 16'h0003, 16'h0000);
        arm(16'h0007);
        go(2'b01);
        fault_input_a_in <= 1'b0;
        tick(6);
        chk("pin", compare_output_pin_out, 16'h0000);
        chk("oe", compare_output_pin_oe_out, 16'h0001);
        rc(`ADDR_CTRL, 16'hffff, 16'h0017);
        rc(`ADDR_STATUS, 16'h0002, 16'h0002);
        chk("irq", irq_out, 16'h0001);
        fault_input_a_in <= 1'b1;
        tick(6);
        rc(`ADDR_CTRL, 16'hffff, 16'h0007);
        $display("pwm done");
        arm(16'h2001);
        cpu_idle_in <= 1'b1;
        go(2'b01);
        tick(60);
        chk("pin", compare_output_pin_out, 16'h0000);
        cpu_idle_in <= 1'b0;
        wait_pin(1'b1);
        arm(16'hdff0);
        rc(`ADDR_CTRL, 16'hffff, 16'h0000);
        port_latch_in <= 1'b1;
        go(2'b01);
        tick(60);
        chk("pin", compare_output_pin_out, 16'h0001);
        chk("oe", compare_output_pin_oe_out, 16'h0000);
        rc(`ADDR_STATUS, 16'h0003, 16'h0000);
        $display("idle and off done");
        end_of_test();
    end
endmodule
